// ---- hw/clock_ctrl.sv ----
// Clock source controller with stable counters, power-down sequencing and clock configuration
`timescale 1ns/10ps
// Function
// - Enter power-down on wait-for-interrupt only when deep sleep select is set.
// - Stay in power-down until a wake-up interrupt arrives.
// - Stop crystal and fast RC oscillators during power-down.
// - PLL reference is crystal when select bit 19 is 0, fast RC when 1.
// - Enabled source starts its stable counter; terminal count sets its status flag.
// - Counts are 4096 crystal, 6144 PLL reference, 256 fast RC, 1 slow RC.
// - System and peripheral selects switch to a source only once it is stable; peripheral gates also close while their source is not.
// - Disabling a source clears its stable flag at once.
// - Power-down clears crystal, fast RC, PLL flags; counts restart after wake-up.
// - System and peripheral clocks each have their own source select and divider; only the peripheral clock has gates, eight of them.
module clock_ctrl #(
  parameter int CRYSTAL_COUNT = clock_ctrl_pkg::CRYSTAL_STABLE_COUNT,
  parameter int PLL_COUNT = clock_ctrl_pkg::PLL_STABLE_COUNT,
  parameter int FAST_RC_COUNT = clock_ctrl_pkg::FAST_RC_STABLE_COUNT,
  parameter int SLOW_RC_COUNT = clock_ctrl_pkg::SLOW_RC_STABLE_COUNT
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Core power events
  input wire logic wfi_i,
  input wire logic wakeup_i,
  // Oscillator outputs, asynchronous to clk_i
  input wire logic ext_crystal_osc_i,
  input wire logic int_fast_rc_osc_i,
  input wire logic int_slow_rc_osc_i,
  // Oscillator controls and clock configuration
  output clock_ctrl_pkg::osc_ctrl_t osc_ctrl_o,
  output clock_ctrl_pkg::clk_cfg_t clk_cfg_o,
  output logic power_down_o
);
  localparam int W = clock_ctrl_pkg::STABLE_CNT_W;

  function automatic logic [31:0] merge_lanes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic src_is_stable(input logic [1:0] sel, input logic [4:0] st);
    logic r;
    r = 1'b0;
    unique case (sel)
      clock_ctrl_pkg::SEL_CRYSTAL: r = st[clock_ctrl_pkg::CRYSTAL_STABLE_BIT];
      clock_ctrl_pkg::SEL_PLL: r = st[clock_ctrl_pkg::PLL_STABLE_BIT];
      clock_ctrl_pkg::SEL_SLOW_RC: r = st[clock_ctrl_pkg::SLOW_RC_STABLE_BIT];
      clock_ctrl_pkg::SEL_FAST_RC: r = st[clock_ctrl_pkg::FAST_RC_STABLE_BIT];
    endcase
    return r;
  endfunction

  // Software registers
  logic [31:0] power_control;
  logic [31:0] pll_control;
  logic [31:0] core_system_control;
  logic [31:0] clock_select;
  logic [31:0] clock_divider;
  logic [31:0] clock_gate;
  clock_ctrl_pkg::power_state_t state;
  logic [1:0] sys_sel_applied;
  logic [1:0] periph_sel_applied;

  // Bus decode
  wire logic bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic bus_wr = bus_req & wb_we_i;
  wire logic [7:0] word_adr = {wb_adr_i[7:2], 2'b00};
  wire logic hit_power = word_adr == clock_ctrl_pkg::POWER_CONTROL_ADDR;
  wire logic hit_pll = word_adr == clock_ctrl_pkg::PLL_CONTROL_ADDR;
  wire logic hit_status = word_adr == clock_ctrl_pkg::CLOCK_STABLE_STATUS_ADDR;
  wire logic hit_scr = word_adr == clock_ctrl_pkg::CORE_SYSTEM_CONTROL_ADDR;
  wire logic hit_sel = word_adr == clock_ctrl_pkg::CLOCK_SELECT_ADDR;
  wire logic hit_div = word_adr == clock_ctrl_pkg::CLOCK_DIVIDER_ADDR;
  wire logic hit_gate = word_adr == clock_ctrl_pkg::CLOCK_GATE_ADDR;

  // Control fields
  wire logic crystal_enable = power_control[clock_ctrl_pkg::CRYSTAL_ENABLE_BIT];
  wire logic fast_rc_enable = power_control[clock_ctrl_pkg::FAST_RC_ENABLE_BIT];
  wire logic slow_rc_enable = power_control[clock_ctrl_pkg::SLOW_RC_ENABLE_BIT];
  wire logic pll_power_down = pll_control[clock_ctrl_pkg::PLL_POWER_DOWN_BIT];
  wire logic pll_reference_select = pll_control[clock_ctrl_pkg::PLL_REFERENCE_SELECT_BIT];
  wire logic deep_sleep_select = core_system_control[clock_ctrl_pkg::DEEP_SLEEP_SELECT_BIT];
  wire logic in_power_down = state == clock_ctrl_pkg::POWERED_DOWN;

  // Power state sequencing
  wire logic enter_pd = wfi_i & deep_sleep_select;
  wire logic leave_pd = wakeup_i;
  clock_ctrl_pkg::power_state_t next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      clock_ctrl_pkg::RUNNING: begin
        if (enter_pd) begin
          next_state = clock_ctrl_pkg::POWERED_DOWN;
        end
      end
      clock_ctrl_pkg::POWERED_DOWN: begin
        if (leave_pd) begin
          next_state = clock_ctrl_pkg::RUNNING;
        end
      end
    endcase
  end
  wire logic next_pd = next_state == clock_ctrl_pkg::POWERED_DOWN;

  // Oscillator sampling: three stages, a level counts once stages two and three agree.
  // Sampling at 50 MHz resolves sources up to about 12.5 MHz; faster crystals undercount edges.
  logic [2:0] osc_raw;
  logic [2:0] osc_filt;
  logic [2:0] osc_filt_d;
  assign osc_raw = {int_slow_rc_osc_i, int_fast_rc_osc_i, ext_crystal_osc_i};
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : osc_sync
      logic s1;
      logic s2;
      logic s3;
      always_ff @(posedge clk_i) begin
        s1 <= osc_raw[g];
        s2 <= s1;
        s3 <= s2;
        if (rst_i) begin
          osc_filt[g] <= 1'b0;
          osc_filt_d[g] <= 1'b0;
        end else begin
          osc_filt[g] <= (s2 == s3) ? s3 : osc_filt[g];
          osc_filt_d[g] <= osc_filt[g];
        end
      end
    end
  endgenerate
  wire logic [2:0] osc_rise = osc_filt & ~osc_filt_d;

  // Stable counter bank
  wire logic pll_ref_edge = pll_reference_select ? osc_rise[1] : osc_rise[0];
  wire logic pll_ref_on = pll_reference_select ? fast_rc_enable : crystal_enable;
  logic [clock_ctrl_pkg::NUM_SRC-1:0] src_edge;
  logic [clock_ctrl_pkg::NUM_SRC-1:0] src_run;
  logic [clock_ctrl_pkg::NUM_SRC-1:0] src_stable;
  logic [W-1:0] src_last [clock_ctrl_pkg::NUM_SRC];
  assign src_edge = {pll_ref_edge, osc_rise[2], osc_rise[1], osc_rise[0]};
  // Disable, or power-down for all but the slow RC, holds a counter and flag at zero, so counting restarts from zero
  assign src_run[clock_ctrl_pkg::SRC_CRYSTAL] = crystal_enable & ~in_power_down;
  assign src_run[clock_ctrl_pkg::SRC_FAST_RC] = fast_rc_enable & ~in_power_down;
  assign src_run[clock_ctrl_pkg::SRC_SLOW_RC] = slow_rc_enable;
  assign src_run[clock_ctrl_pkg::SRC_PLL] = ~pll_power_down & pll_ref_on & ~in_power_down;
  assign src_last[clock_ctrl_pkg::SRC_CRYSTAL] = W'(CRYSTAL_COUNT - 1);
  assign src_last[clock_ctrl_pkg::SRC_FAST_RC] = W'(FAST_RC_COUNT - 1);
  assign src_last[clock_ctrl_pkg::SRC_SLOW_RC] = W'(SLOW_RC_COUNT - 1);
  assign src_last[clock_ctrl_pkg::SRC_PLL] = W'(PLL_COUNT - 1);
  generate
    for (g = 0; g < clock_ctrl_pkg::NUM_SRC; g++) begin : stab
      logic [W-1:0] cnt;
      always_ff @(posedge clk_i) begin
        if (rst_i || !src_run[g]) begin
          cnt <= '0;
          src_stable[g] <= 1'b0;
        end else if (src_edge[g] && !src_stable[g]) begin
          if (cnt == src_last[g]) begin
            src_stable[g] <= 1'b1;
          end else begin
            cnt <= cnt + W'(1);
          end
        end
      end
    end
  endgenerate

  // Status word in its documented bit layout
  logic [4:0] status_bits;
  assign status_bits[clock_ctrl_pkg::CRYSTAL_STABLE_BIT] = src_stable[clock_ctrl_pkg::SRC_CRYSTAL];
  assign status_bits[1] = 1'b0;
  assign status_bits[clock_ctrl_pkg::PLL_STABLE_BIT] = src_stable[clock_ctrl_pkg::SRC_PLL];
  assign status_bits[clock_ctrl_pkg::SLOW_RC_STABLE_BIT] = src_stable[clock_ctrl_pkg::SRC_SLOW_RC];
  assign status_bits[clock_ctrl_pkg::FAST_RC_STABLE_BIT] = src_stable[clock_ctrl_pkg::SRC_FAST_RC];

  // Read mux; unmapped offsets read zero and ignore writes
  wire logic [31:0] read_data =
    hit_power ? power_control :
    hit_pll ? pll_control :
    hit_status ? {27'h0, status_bits} :
    hit_scr ? core_system_control :
    hit_sel ? clock_select :
    hit_div ? clock_divider :
    hit_gate ? clock_gate : 32'h00000000;

  // Requested selections take effect only once the target is stable; until then the old one stays
  wire logic [1:0] sys_sel_req = clock_select[clock_ctrl_pkg::SYS_SEL_LSB +: 2];
  wire logic [1:0] periph_sel_req = clock_select[clock_ctrl_pkg::PERIPH_SEL_LSB +: 2];
  wire logic [1:0] next_sys_sel = src_is_stable(sys_sel_req, status_bits) ? sys_sel_req : sys_sel_applied;
  wire logic [1:0] next_periph_sel =
    src_is_stable(periph_sel_req, status_bits) ? periph_sel_req : periph_sel_applied;
  wire logic periph_ok = src_is_stable(periph_sel_applied, status_bits);

  // Bus slave and registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      power_control <= clock_ctrl_pkg::POWER_CONTROL_RESET;
      pll_control <= clock_ctrl_pkg::PLL_CONTROL_RESET;
      core_system_control <= clock_ctrl_pkg::CORE_SYSTEM_CONTROL_RESET;
      clock_select <= clock_ctrl_pkg::CLOCK_SELECT_RESET;
      clock_divider <= clock_ctrl_pkg::CLOCK_DIVIDER_RESET;
      clock_gate <= clock_ctrl_pkg::CLOCK_GATE_RESET;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? read_data : 32'h00000000;
      if (bus_wr && hit_power) begin
        power_control <= merge_lanes(power_control, wb_dat_i, wb_sel_i) & clock_ctrl_pkg::POWER_CONTROL_MASK;
      end
      if (bus_wr && hit_pll) begin
        pll_control <= merge_lanes(pll_control, wb_dat_i, wb_sel_i) & clock_ctrl_pkg::PLL_CONTROL_MASK;
      end
      if (bus_wr && hit_scr) begin
        core_system_control <= merge_lanes(core_system_control, wb_dat_i, wb_sel_i) &
                               clock_ctrl_pkg::CORE_SYSTEM_CONTROL_MASK;
      end
      if (bus_wr && hit_sel) begin
        clock_select <= merge_lanes(clock_select, wb_dat_i, wb_sel_i) & clock_ctrl_pkg::CLOCK_SELECT_MASK;
      end
      if (bus_wr && hit_div) begin
        clock_divider <= merge_lanes(clock_divider, wb_dat_i, wb_sel_i) & clock_ctrl_pkg::CLOCK_DIVIDER_MASK;
      end
      if (bus_wr && hit_gate) begin
        clock_gate <= merge_lanes(clock_gate, wb_dat_i, wb_sel_i) & clock_ctrl_pkg::CLOCK_GATE_MASK;
      end
    end
  end

  // Power state, oscillator controls and clock configuration outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= clock_ctrl_pkg::RUNNING;
      power_down_o <= 1'b0;
      osc_ctrl_o <= '0;
      sys_sel_applied <= clock_ctrl_pkg::SEL_FAST_RC;
      periph_sel_applied <= clock_ctrl_pkg::SEL_FAST_RC;
      clk_cfg_o <= '0;
    end else begin
      state <= next_state;
      power_down_o <= next_pd;
      osc_ctrl_o.crystal_enable <= crystal_enable & ~next_pd;
      osc_ctrl_o.fast_rc_enable <= fast_rc_enable & ~next_pd;
      osc_ctrl_o.slow_rc_enable <= slow_rc_enable;
      osc_ctrl_o.pll_enable <= ~pll_power_down & ~next_pd;
      osc_ctrl_o.pll_reference_select <= pll_reference_select;
      sys_sel_applied <= next_sys_sel;
      periph_sel_applied <= next_periph_sel;
      clk_cfg_o.sys_sel <= next_sys_sel;
      clk_cfg_o.periph_sel <= next_periph_sel;
      clk_cfg_o.sys_div <= clock_divider[clock_ctrl_pkg::SYS_DIV_LSB +: 4];
      clk_cfg_o.periph_div <= clock_divider[clock_ctrl_pkg::PERIPH_DIV_LSB +: 4];
      // A peripheral gate only opens while its applied source is stable
      clk_cfg_o.gate <= clock_gate[7:0] & {8{periph_ok}};
    end
  end
endmodule // clock_ctrl

// ---- hw/clock_ctrl_pkg.sv ----
// Package for the clock source controller: register map, fields, reset values and counts
package clock_ctrl_pkg;
  // Register byte offsets
  localparam logic [7:0] POWER_CONTROL_ADDR = 8'h00;
  localparam logic [7:0] PLL_CONTROL_ADDR = 8'h04;
  localparam logic [7:0] CLOCK_STABLE_STATUS_ADDR = 8'h08;
  localparam logic [7:0] CORE_SYSTEM_CONTROL_ADDR = 8'h0C;
  localparam logic [7:0] CLOCK_SELECT_ADDR = 8'h10;
  localparam logic [7:0] CLOCK_DIVIDER_ADDR = 8'h14;
  localparam logic [7:0] CLOCK_GATE_ADDR = 8'h18;

  // Field positions
  localparam int CRYSTAL_ENABLE_BIT = 0;
  localparam int FAST_RC_ENABLE_BIT = 2;
  localparam int SLOW_RC_ENABLE_BIT = 3;
  localparam int PLL_POWER_DOWN_BIT = 16;
  localparam int PLL_REFERENCE_SELECT_BIT = 19;
  localparam int DEEP_SLEEP_SELECT_BIT = 2;
  localparam int CRYSTAL_STABLE_BIT = 0;
  localparam int PLL_STABLE_BIT = 2;
  localparam int SLOW_RC_STABLE_BIT = 3;
  localparam int FAST_RC_STABLE_BIT = 4;
  localparam int SYS_SEL_LSB = 0;
  localparam int PERIPH_SEL_LSB = 4;
  localparam int SYS_DIV_LSB = 0;
  localparam int PERIPH_DIV_LSB = 4;

  // Writable bits; everything else reads as zero
  localparam logic [31:0] POWER_CONTROL_MASK = 32'h0000000D;
  localparam logic [31:0] PLL_CONTROL_MASK = 32'h00090000;
  localparam logic [31:0] CORE_SYSTEM_CONTROL_MASK = 32'h00000004;
  localparam logic [31:0] CLOCK_SELECT_MASK = 32'h00000033;
  localparam logic [31:0] CLOCK_DIVIDER_MASK = 32'h000000FF;
  localparam logic [31:0] CLOCK_GATE_MASK = 32'h000000FF;

  // Values after reset
  localparam logic [31:0] POWER_CONTROL_RESET = 32'h0000000C;
  localparam logic [31:0] PLL_CONTROL_RESET = 32'h00010000;
  localparam logic [31:0] CORE_SYSTEM_CONTROL_RESET = 32'h00000000;
  localparam logic [31:0] CLOCK_SELECT_RESET = 32'h00000033;
  localparam logic [31:0] CLOCK_DIVIDER_RESET = 32'h00000000;
  localparam logic [31:0] CLOCK_GATE_RESET = 32'h00000000;

  // Stable counts in edges of the source being watched
  localparam int CRYSTAL_STABLE_COUNT = 4096;
  localparam int PLL_STABLE_COUNT = 6144;
  localparam int FAST_RC_STABLE_COUNT = 256;
  localparam int SLOW_RC_STABLE_COUNT = 1;
  localparam int STABLE_CNT_W = 13;

  // Source select codes
  localparam logic [1:0] SEL_CRYSTAL = 2'h0;
  localparam logic [1:0] SEL_PLL = 2'h1;
  localparam logic [1:0] SEL_SLOW_RC = 2'h2;
  localparam logic [1:0] SEL_FAST_RC = 2'h3;

  // Source index in the stable counter bank
  localparam int SRC_CRYSTAL = 0;
  localparam int SRC_FAST_RC = 1;
  localparam int SRC_SLOW_RC = 2;
  localparam int SRC_PLL = 3;
  localparam int NUM_SRC = 4;

  typedef enum logic {RUNNING, POWERED_DOWN} power_state_t;

  typedef struct packed {
    logic pll_reference_select;
    logic pll_enable;
    logic slow_rc_enable;
    logic fast_rc_enable;
    logic crystal_enable;
  } osc_ctrl_t;

  typedef struct packed {
    logic [7:0] gate;
    logic [3:0] periph_div;
    logic [3:0] sys_div;
    logic [1:0] periph_sel;
    logic [1:0] sys_sel;
  } clk_cfg_t;
endpackage

// ---- bench/clock_ctrl_properties.sv ----
// Concurrent checks on the clock controller ports
`timescale 1ns/10ps
module clock_ctrl_props (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Power and oscillators
  input wire logic wfi_i,
  input wire logic wakeup_i,
  input wire clock_ctrl_pkg::osc_ctrl_t osc_ctrl_o,
  input wire logic power_down_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  chk_sleep_cause: assert property ($rose(power_down_o) |-> $past(wfi_i))
    else $error("power-down without wait-for-interrupt");
  chk_no_sleep_idle: assert property (!power_down_o && !wfi_i |=> !power_down_o)
    else $error("power-down entered spontaneously");
  chk_sleep_stays: assert property (power_down_o && !wakeup_i |=> power_down_o)
    else $error("power-down left without wake-up");
  chk_wake_cause: assert property ($fell(power_down_o) |-> $past(wakeup_i))
    else $error("power-down left without wake-up event");
  chk_sleep_osc_off: assert property (power_down_o |->
    !osc_ctrl_o.crystal_enable && !osc_ctrl_o.fast_rc_enable && !osc_ctrl_o.pll_enable)
    else $error("fast oscillator running in power-down");
  chk_slow_kept: assert property ($rose(power_down_o) |-> $stable(osc_ctrl_o.slow_rc_enable))
    else $error("slow oscillator changed on power-down");

  cover property ($rose(power_down_o));
  cover property ($fell(power_down_o));
  cover property (wb_ack_o && wb_dat_o != 32'h0);
endmodule // clock_ctrl_props

// ---- bench/tb_clock_ctrl.sv ----
// Self-checking bench for the clock source controller
`timescale 1ns/10ps
module tb_clock_ctrl;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wfi_i, wakeup_i, wb_ack_o, power_down_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic xtal = 1'b0, frc = 1'b0, src = 1'b0;
  clock_ctrl_pkg::osc_ctrl_t osc_ctrl_o;
  clock_ctrl_pkg::clk_cfg_t clk_cfg_o;
  int error_cnt = 0, compares = 0, cyc_cnt = 0, tick = 0;
  // Small stable counts keep the run short; periods are 8, 10 and 14 clocks
  localparam int NX = 8, NP = 12, NF = 4;
  clock_ctrl #(.CRYSTAL_COUNT(NX), .PLL_COUNT(NP), .FAST_RC_COUNT(NF), .SLOW_RC_COUNT(1)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wfi_i(wfi_i), .wakeup_i(wakeup_i), .ext_crystal_osc_i(xtal),
    .int_fast_rc_osc_i(frc), .int_slow_rc_osc_i(src), .osc_ctrl_o(osc_ctrl_o),
    .clk_cfg_o(clk_cfg_o), .power_down_o(power_down_o));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Oscillators stand still while their enable is low, as real ones do
  always @(posedge clk_i) begin
    tick <= tick + 1;
    cyc_cnt <= cyc_cnt + 1;
    if (tick % 4 == 0 && osc_ctrl_o.crystal_enable) xtal <= ~xtal;
    if (tick % 5 == 0 && osc_ctrl_o.fast_rc_enable) frc <= ~frc;
    if (tick % 7 == 0 && osc_ctrl_o.slow_rc_enable) src <= ~src;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task wrap_up;
    if (error_cnt == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Ack is read in the active region, so it is the value sampled at this edge
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    // A request that is never answered ends the run through the common verdict
    if (k >= 20) begin
      error_cnt++;
      wrap_up();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    check(rd, exp);
  endtask

  task t_reset;
    rchk(clock_ctrl_pkg::CLOCK_STABLE_STATUS_ADDR, 32'h0);
    rchk(clock_ctrl_pkg::POWER_CONTROL_ADDR, clock_ctrl_pkg::POWER_CONTROL_RESET);
    rchk(clock_ctrl_pkg::PLL_CONTROL_ADDR, clock_ctrl_pkg::PLL_CONTROL_RESET);
    rchk(clock_ctrl_pkg::CLOCK_SELECT_ADDR, clock_ctrl_pkg::CLOCK_SELECT_RESET);
    rchk(clock_ctrl_pkg::CLOCK_DIVIDER_ADDR, clock_ctrl_pkg::CLOCK_DIVIDER_RESET);
    rchk(clock_ctrl_pkg::CLOCK_GATE_ADDR, clock_ctrl_pkg::CLOCK_GATE_RESET);
    wr(8'h1C, 32'hFFFFFFFF);
    rchk(8'h1C, 32'h0);
    wr(clock_ctrl_pkg::CORE_SYSTEM_CONTROL_ADDR, 32'hFFFFFFFF);
    rchk(clock_ctrl_pkg::CORE_SYSTEM_CONTROL_ADDR, 32'h4);
    wr(clock_ctrl_pkg::CORE_SYSTEM_CONTROL_ADDR, 32'h0);
  endtask

  task t_stable;
    repeat (NF * 10 + 20) @(posedge clk_i);
    rchk(clock_ctrl_pkg::CLOCK_STABLE_STATUS_ADDR, 32'h18);
    wr(clock_ctrl_pkg::POWER_CONTROL_ADDR, 32'hD);
    repeat ((NX - 2) * 8) @(posedge clk_i);
    rchk(clock_ctrl_pkg::CLOCK_STABLE_STATUS_ADDR, 32'h18);
    repeat (32) @(posedge clk_i);
    rchk(clock_ctrl_pkg::CLOCK_STABLE_STATUS_ADDR, 32'h19);
    wr(clock_ctrl_pkg::PLL_CONTROL_ADDR, 32'h0);
    repeat ((NP - 2) * 8) @(posedge clk_i);
    rchk(clock_ctrl_pkg::CLOCK_STABLE_STATUS_ADDR, 32'h19);
    repeat (32) @(posedge clk_i);
    rchk(clock_ctrl_pkg::CLOCK_STABLE_STATUS_ADDR, 32'h1D);
    check(32'(osc_ctrl_o), 32'hF);
  endtask

  task t_select;
    wr(clock_ctrl_pkg::CLOCK_SELECT_ADDR, 32'h10);
    wr(clock_ctrl_pkg::CLOCK_DIVIDER_ADDR, 32'hA5);
    wr(clock_ctrl_pkg::CLOCK_GATE_ADDR, 32'h3C);
    repeat (3) @(posedge clk_i);
    check(32'(clk_cfg_o), 32'h3CA54);
    wr(clock_ctrl_pkg::POWER_CONTROL_ADDR, 32'hC);
    bus(clock_ctrl_pkg::CLOCK_STABLE_STATUS_ADDR, 1'b0, 32'h0);
    check(rd & 32'h19, 32'h18);
    wr(clock_ctrl_pkg::CLOCK_SELECT_ADDR, 32'h33);
    wr(clock_ctrl_pkg::CLOCK_SELECT_ADDR, 32'h30);
    repeat (3) @(posedge clk_i);
    check(32'(clk_cfg_o), 32'h3CA5F);
  endtask

  task t_pllref;
    wr(clock_ctrl_pkg::PLL_CONTROL_ADDR, 32'h80000);
    repeat (3) @(posedge clk_i);
    check(32'(osc_ctrl_o), 32'h1E);
    repeat ((NP + 4) * 10) @(posedge clk_i);
    rchk(clock_ctrl_pkg::CLOCK_STABLE_STATUS_ADDR, 32'h1C);
    wr(clock_ctrl_pkg::PLL_CONTROL_ADDR, 32'h90000);
    rchk(clock_ctrl_pkg::CLOCK_STABLE_STATUS_ADDR, 32'h18);
  endtask

  task pulse_wfi;
    @(posedge clk_i) wfi_i <= 1'b1;
    @(posedge clk_i) wfi_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task t_sleep;
    wr(clock_ctrl_pkg::POWER_CONTROL_ADDR, 32'hD);
    wr(clock_ctrl_pkg::PLL_CONTROL_ADDR, 32'h0);
    repeat (150) @(posedge clk_i);
    pulse_wfi();
    check(32'(power_down_o), 32'h0);
    wr(clock_ctrl_pkg::CORE_SYSTEM_CONTROL_ADDR, 32'h4);
    pulse_wfi();
    check(32'(power_down_o), 32'h1);
    check(32'(osc_ctrl_o), 32'h4);
    rchk(clock_ctrl_pkg::CLOCK_STABLE_STATUS_ADDR, 32'h8);
    repeat (50) @(posedge clk_i);
    check(32'(power_down_o), 32'h1);
    @(posedge clk_i) wakeup_i <= 1'b1;
    @(posedge clk_i) wakeup_i <= 1'b0;
    @(posedge clk_i);
    check(32'(power_down_o), 32'h0);
    rchk(clock_ctrl_pkg::CLOCK_STABLE_STATUS_ADDR, 32'h8);
    repeat (150) @(posedge clk_i);
    rchk(clock_ctrl_pkg::CLOCK_STABLE_STATUS_ADDR, 32'h1D);
  endtask

  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wfi_i, wakeup_i} = 5'h0;
    wb_adr_i = 8'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_stable();
    t_select();
    t_pllref();
    t_sleep();
    wrap_up();
  end
endmodule // tb_clock_ctrl

bind clock_ctrl clock_ctrl_props chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wfi_i(wfi_i),
  .wakeup_i(wakeup_i), .osc_ctrl_o(osc_ctrl_o), .power_down_o(power_down_o));
